// ==== hw/aim_cfg.svh ====
`ifndef AIM_CFG_SVH
`define AIM_CFG_SVH
`define AIM_CLK_NS 10
`define AIM_IDX_PT_LAST 4'hb
`define AIM_IDX_QUAL 4'hc
`define AIM_IDX_CFG 4'hd
`define AIM_B_CONF 0
`define AIM_B_FORCE 1
`define AIM_B_CAL 7
`define AIM_B_50HZ 8
`define AIM_B_SYNC 9
`define AIM_B_TRACK 10
`define AIM_B_PE 11
`define AIM_B_TICK 12
`define AIM_B_MEM 13
`define AIM_B_SENS 14
`define AIM_B_FAULT 15
`define AIM_CFG_RST 4'h0
`define AIM_TB60_NS 83300000
`define AIM_TB50_NS 80000000
`define AIM_INIT_WIN_NS 6400
`define AIM_INIT_CYC (`AIM_INIT_WIN_NS / `AIM_CLK_NS)
`endif

// ==== hw/aim_pkg.sv ====
`include "aim_cfg.svh"
package aim_pkg;
  // Whole register state of the block
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] dat;
    logic conf;
    logic force_err;
    logic sel_50hz;
    logic use_sync;
    logic [2:0] tick_sy;
    logic [1:0] pe_sy;
    logic [1:0] trk_sy;
    logic [9:0] init_cnt;
    logic tick_seen;
    logic tick_fail;
    logic [23:0] integ_cnt;
    logic integ;
    logic [11:0][15:0] pts;
  } state_s;
endpackage

// ==== hw/module_cfg_status.sv ====
`include "aim_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module module_cfg_status #(
  parameter int INTEG60_CYC = `AIM_TB60_NS / `AIM_CLK_NS,
  parameter int INTEG50_CYC = `AIM_TB50_NS / `AIM_CLK_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Pins from outside the clock domain
  input wire logic ref_tick_i,
  input wire logic calib_memory_program_enable_i,
  input wire logic line_track_i,
  // Self-test and monitor results, same clock
  input wire logic cal_cksum_err_i,
  input wire logic mem_err_i,
  input wire logic internal_err_i,
  input wire logic sensor_fail_i,
  input wire logic [15:0] quality_i,
  // Point data from the converter, same clock
  input wire logic pt_wr_i,
  input wire logic [3:0] pt_idx_i,
  input wire logic [15:0] pt_dat_i,
  // Programming command gate
  input wire logic prog_cmd_i,
  output logic prog_cmd_ok_o,
  // Module outputs
  output logic err_led_o,
  output logic sel_50hz_o,
  output logic use_sync_o,
  output logic integ_o,
  output logic halt_o
);

  localparam int INIT_CYC = `AIM_INIT_CYC;

  aim_pkg::state_s q, d;

  // Point data words, index 0 to 11
  function automatic logic is_point(input logic [3:0] idx);
    is_point = (idx <= `AIM_IDX_PT_LAST);
  endfunction

  logic req;
  logic [3:0] idx;
  logic cal_err;
  logic err_bit;
  logic pt_fault;
  logic [15:0] status;
  logic attn;
  logic [23:0] integ_max;

  // Request decode
  assign req = cyc_i && stb_i && !q.ack && !q.err;
  assign idx = adr_i[5:2];

  // Error sources
  assign cal_err = cal_cksum_err_i;

  // error bit covers all module errors
  assign err_bit = q.force_err || internal_err_i || cal_err
    || q.tick_fail || mem_err_i;

  // sensor fault kept out of the summary
  assign pt_fault = (|quality_i) || err_bit || cal_err
    || q.tick_fail || mem_err_i;

  // attention on point words while unconfigured or in error
  // attention on point reads in error
  assign attn = is_point(idx) && (!q.conf || err_bit);

  // timebase length from the 50 Hz select
  assign integ_max = q.sel_50hz ? 24'(INTEG50_CYC - 1)
                                : 24'(INTEG60_CYC - 1);

  // Status word
  always_comb begin
    status = 16'h0000;
    status[`AIM_B_CONF] = q.conf;
    status[`AIM_B_FORCE] = err_bit;
    // bits 2 to 6 stay zero
    status[`AIM_B_CAL] = cal_err;
    status[`AIM_B_50HZ] = q.sel_50hz;
    status[`AIM_B_SYNC] = q.use_sync && q.trk_sy[1];
    status[`AIM_B_TRACK] = q.trk_sy[1];
    status[`AIM_B_PE] = q.pe_sy[1];
    status[`AIM_B_TICK] = q.tick_fail;
    status[`AIM_B_MEM] = mem_err_i;
    status[`AIM_B_SENS] = sensor_fail_i || cal_err;
    status[`AIM_B_FAULT] = pt_fault;
  end

  // Next state
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.integ = 1'b0;
    // Synchronisers for the pins
    d.tick_sy = {q.tick_sy[1:0], ref_tick_i};
    d.pe_sy = {q.pe_sy[0], calib_memory_program_enable_i};
    d.trk_sy = {q.trk_sy[0], line_track_i};
    // look for a tick during the init window
    if (q.init_cnt != 10'h000) begin
      d.init_cnt = q.init_cnt - 10'h001;
      if (q.tick_sy[1] && !q.tick_sy[2]) begin
        d.tick_seen = 1'b1;
      end
      if (q.init_cnt == 10'h001 && !d.tick_seen) begin
        d.tick_fail = 1'b1;
      end
    end
    if (cal_err) begin
      d.integ_cnt = 24'h000000;
    end else if (q.integ_cnt >= integ_max) begin
      d.integ_cnt = 24'h000000;
      d.integ = 1'b1;
    end else begin
      d.integ_cnt = q.integ_cnt + 24'h000001;
    end
    if (pt_wr_i && !cal_err && is_point(pt_idx_i)) begin
      d.pts[pt_idx_i] = pt_dat_i;
    end
    // Bus access
    if (req) begin
      d.dat = 32'h00000000;
      if (idx == `AIM_IDX_CFG) begin
        d.ack = 1'b1;
        if (we_i) begin
          // only bits 0, 1, 8, 9 are stored
          if (sel_i[0]) begin
            d.conf = dat_i[`AIM_B_CONF];
            d.force_err = dat_i[`AIM_B_FORCE];
          end
          if (sel_i[1]) begin
            d.sel_50hz = dat_i[`AIM_B_50HZ];
            d.use_sync = dat_i[`AIM_B_SYNC];
          end
        end else begin
          d.dat = {16'h0000, status};
        end
      end else if (idx == `AIM_IDX_QUAL) begin
        d.ack = 1'b1;
        // quality hidden under forced, calibration, tick or memory error
        if (!we_i && !(q.force_err || cal_err
            || q.tick_fail || mem_err_i)) begin
          d.dat = {16'h0000, quality_i};
        end
      end else if (attn) begin
        d.err = 1'b1;
      end else if (is_point(idx)) begin
        d.ack = 1'b1;
        if (!we_i) begin
          d.dat = {16'h0000, q.pts[idx]};
        end
      end else begin
        // Unmapped word
        d.err = 1'b1;
      end
    end
    if (rst_i) begin
      d.ack = 1'b0;
      d.err = 1'b0;
      d.dat = 32'h00000000;
      {d.use_sync, d.sel_50hz, d.force_err, d.conf} = `AIM_CFG_RST;
      d.tick_sy = 3'h0;
      d.pe_sy = 2'h0;
      d.trk_sy = 2'h0;
      d.init_cnt = 10'(INIT_CYC);
      d.tick_seen = 1'b0;
      d.tick_fail = 1'b0;
      d.integ_cnt = 24'h000000;
      d.integ = 1'b0;
      d.pts = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // Outputs
  assign dat_o = q.dat;
  assign ack_o = q.ack;
  assign err_o = q.err;
  assign err_led_o = err_bit;
  assign sel_50hz_o = q.sel_50hz;
  assign use_sync_o = status[`AIM_B_SYNC];
  assign integ_o = q.integ;
  assign halt_o = cal_err;
  assign prog_cmd_ok_o = prog_cmd_i && q.pe_sy[1];

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_cfg_write: assert property (
    req && we_i && idx == `AIM_IDX_CFG && sel_i[0]
    |=> q.conf == $past(dat_i[0]) && ack_o)
    else $error("config bit 0 not stored");

  chk_attn_unconf: assert property (
    req && is_point(idx) && !q.conf |=> err_o && !ack_o)
    else $error("no attention while unconfigured");

  chk_force_err: assert property (
    req && we_i && idx == `AIM_IDX_CFG && sel_i[0] && dat_i[1]
    |=> err_led_o)
    else $error("forced error not shown");

  chk_err_led: assert property (
    ack_o && $past(idx == `AIM_IDX_CFG && !we_i)
    |-> dat_o[`AIM_B_FORCE] == $past(err_led_o))
    else $error("indicator differs from bit 1");

  chk_attn_err: assert property (
    req && !we_i && is_point(idx) && err_bit |=> err_o)
    else $error("no attention in error");

  chk_unused_zero: assert property (
    ack_o && $past(idx) == `AIM_IDX_CFG && !$past(we_i)
    |-> dat_o[6:2] == 5'h00)
    else $error("unused status bits not zero");

  chk_cal_halt: assert property (
    cal_err [*2] |-> !integ_o)
    else $error("processing during calibration error");

  chk_sensor_uncal: assert property (
    cal_err |-> status[`AIM_B_SENS] && status[`AIM_B_FAULT])
    else $error("uncalibrated module hides sensor fault");

  chk_summary: assert property (
    (|quality_i) |-> status[`AIM_B_FAULT])
    else $error("point fault not summarised");

  chk_qual_gate: assert property (
    req && !we_i && idx == `AIM_IDX_QUAL && q.force_err
    |=> ack_o && dat_o == 32'h00000000)
    else $error("quality shown under module error");

  chk_tick_fail: assert property (
    q.init_cnt == 10'h001 && !q.tick_seen
    && !(q.tick_sy[1] && !q.tick_sy[2]) |=> q.tick_fail)
    else $error("missing tick not flagged");

  // Bus answers and read data
  chk_status_read: assert property (
    req && !we_i && idx == `AIM_IDX_CFG
    |=> ack_o && dat_o == {16'h0000, $past(status)})
    else $error("status read returned wrong word");

  chk_unmapped: assert property (
    req && idx > `AIM_IDX_CFG |=> err_o && !ack_o)
    else $error("unmapped word not refused");

  chk_point_read: assert property (
    req && !we_i && is_point(idx) && q.conf && !err_led_o
    |=> ack_o && dat_o == {16'h0000, $past(q.pts[idx])})
    else $error("point read refused or wrong");

  chk_cal_flags: assert property (
    cal_cksum_err_i
    |-> err_led_o && status[`AIM_B_CAL] && status[`AIM_B_FAULT])
    else $error("calibration error not flagged");

  chk_cal_freeze: assert property (
    cal_cksum_err_i |=> $stable(q.pts))
    else $error("point data changed while uncalibrated");

  chk_integ_end: assert property (
    !cal_cksum_err_i && q.integ_cnt == integ_max
    |=> integ_o && q.integ_cnt == 24'h000000)
    else $error("integration period end missed");

  chk_sync_use: assert property (
    use_sync_o |-> q.use_sync && status[`AIM_B_TRACK])
    else $error("tracking used without request or signal");

  // Pin mirrors lag the pins by the two synchroniser stages
  chk_track_pin: assert property (
    !$past(rst_i) && !$past(rst_i, 2)
    |-> status[`AIM_B_TRACK] == $past(line_track_i, 2))
    else $error("tracking status does not follow pin");

  chk_pe_mirror: assert property (
    !$past(rst_i) && !$past(rst_i, 2)
    |-> status[`AIM_B_PE] == $past(calib_memory_program_enable_i, 2))
    else $error("program enable not mirrored");

  chk_prog_gate: assert property (
    prog_cmd_ok_o |-> prog_cmd_i && status[`AIM_B_PE])
    else $error("programming passed without enable");

  chk_tick_ok: assert property (
    q.tick_seen |-> !q.tick_fail)
    else $error("tick failure despite seen tick");

  chk_mem_bit: assert property (
    mem_err_i |-> status[`AIM_B_MEM] && err_led_o && status[`AIM_B_FAULT])
    else $error("memory error not flagged");

  chk_sensor_bit: assert property (
    status[`AIM_B_SENS] == (sensor_fail_i || cal_cksum_err_i))
    else $error("sensor fault bit wrong");

  chk_fault_why: assert property (
    status[`AIM_B_FAULT] |-> (|quality_i) || err_led_o)
    else $error("summary fault without a cause");

  chk_qual_show: assert property (
    req && !we_i && idx == `AIM_IDX_QUAL && !err_led_o
    |=> ack_o && dat_o == {16'h0000, $past(quality_i)})
    else $error("quality word not shown");

  chk_sensor_apart: assert property (
    sensor_fail_i && !err_led_o && quality_i == 16'h0000
    |-> !status[`AIM_B_FAULT])
    else $error("sensor fault leaked into summary");

  chk_cfg_hold: assert property (
    !(req && we_i && idx == `AIM_IDX_CFG)
    |=> $stable({q.conf, q.force_err, q.sel_50hz, q.use_sync}))
    else $error("config changed without a write");

  // Main scenarios seen
  cov_cfg_read: cover property (
    req && !we_i && idx == `AIM_IDX_CFG ##1 ack_o);
  cov_attn: cover property (req && attn ##1 err_o);
  cov_integ: cover property (integ_o);
  cov_cal_halt: cover property (cal_cksum_err_i [*2]);
  cov_tick_fail: cover property ($rose(q.tick_fail));

endmodule // module_cfg_status
`default_nettype wire

// ==== test/analog_input_module_cfg_status_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module analog_input_module_cfg_status_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [5:0] adr_i = 6'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, err_o, ref_tick, pt_wr, prog_ok, led, s50o, synco, halt, integ;
  logic tick_en = 1'b1, pe = 1'b0, trk = 1'b0, cal = 1'b0, mem = 1'b0;
  logic ie = 1'b0, sens = 1'b0, prog = 1'b0;
  logic [15:0] qual = 16'h0, pt_dat;
  logic [3:0] pt_idx;
  int bad_count = 0, n_tests = 0, cyc_n = 0;
  // Short integration periods for simulation
  localparam int P60 = 50;
  localparam int P50 = 40;
  // Clock
  always #5 clk_i = ~clk_i;
  module_cfg_status #(.INTEG60_CYC(P60), .INTEG50_CYC(P50)) module_cfg_status_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .ref_tick_i(ref_tick), .calib_memory_program_enable_i(pe),
    .line_track_i(trk), .cal_cksum_err_i(cal), .mem_err_i(mem), .internal_err_i(ie),
    .sensor_fail_i(sens), .quality_i(qual), .pt_wr_i(pt_wr), .pt_idx_i(pt_idx),
    .pt_dat_i(pt_dat), .prog_cmd_i(prog), .prog_cmd_ok_o(prog_ok), .err_led_o(led),
    .sel_50hz_o(s50o), .use_sync_o(synco), .integ_o(integ), .halt_o(halt));
  front_end_model front_end_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .tick_en_i(tick_en), .ref_tick_o(ref_tick), .pt_wr_o(pt_wr),
    .pt_idx_o(pt_idx), .pt_dat_o(pt_dat));
  // Expected status word from config and monitor levels
  function automatic logic [31:0] exp_st(input logic c, f, s5, sy, tf);
    logic e1;
    e1 = f | ie | cal | tf | mem;
    return {16'h0, e1 | (|qual), sens | cal, mem, tf, pe, trk, sy & trk, s5,
            cal, 5'h00, e1, c};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One classic cycle; read data and err compared
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] er, input logic ee);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {a, 2'b00};
    dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && i < 50);
    chk({31'h0, ack_o | err_o}, 32'h1);
    chk(dat_o, er);
    chk({31'h0, err_o}, {31'h0, ee});
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic t_reset();
    xfer(0, 4'hd, 0, exp_st(0, 0, 0, 0, 0), 0);
    xfer(0, 4'h0, 0, 0, 1);
    xfer(0, 4'hb, 0, 0, 1);
    xfer(0, 4'he, 0, 0, 1);
    $display("reset test done");
  endtask
  task automatic t_config();
    xfer(1, 4'hd, 32'h00fd, 0, 0);
    xfer(0, 4'hd, 0, exp_st(1, 0, 0, 0, 0), 0);
    xfer(0, 4'h5, 0, 32'h0000a505, 0);
    trk <= 1'b1;
    xfer(1, 4'hd, 32'h0301, 0, 0);
    xfer(0, 4'hd, 0, exp_st(1, 0, 1, 1, 0), 0);
    chk({30'h0, s50o, synco}, 32'h3);
    $display("config test done");
  endtask
  task automatic t_force();
    qual <= 16'h8001;
    xfer(1, 4'hd, 32'h0003, 0, 0);
    chk({31'h0, led}, 32'h1);
    xfer(0, 4'hb, 0, 0, 1);
    xfer(0, 4'hc, 0, 0, 0);
    xfer(0, 4'hd, 0, exp_st(1, 1, 0, 0, 0), 0);
    xfer(1, 4'hd, 32'h0001, 0, 0);
    xfer(0, 4'hc, 0, 32'h8001, 0);
    xfer(0, 4'hd, 0, exp_st(1, 0, 0, 0, 0), 0);
    chk({31'h0, led}, 32'h0);
    qual <= 16'h0;
    $display("force test done");
  endtask
  task automatic t_faults();
    for (int i = 0; i < 5; i++) begin
      {cal, mem, ie, sens, pe} <= 5'h10 >> i;
      prog <= 1'b1;
      repeat (6) @(posedge clk_i);
      xfer(0, 4'hd, 0, exp_st(1, 0, 0, 0, 0), 0);
      chk({29'h0, led, halt, prog_ok}, {29'h0, cal | mem | ie, cal, pe});
    end
    {pe, prog} <= 2'b00;
    $display("fault table test done");
  endtask
  task automatic t_tick();
    tick_en <= 1'b0;
    do_reset();
    repeat (700) @(posedge clk_i);
    xfer(0, 4'hd, 0, exp_st(0, 0, 0, 0, 1), 0);
    chk({31'h0, led}, 32'h1);
    tick_en <= 1'b1;
    $display("tick test done");
  endtask
  // Wait for the next integration pulse, counting cycles
  task automatic wait_integ(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (integ !== 1'b1 && n < 200);
  endtask
  task automatic t_integ();
    int n;
    wait_integ(n);
    wait_integ(n);
    chk(n, P60);
    xfer(1, 4'hd, 32'h0101, 0, 0);
    wait_integ(n);
    wait_integ(n);
    chk(n, P50);
    cal <= 1'b1;
    wait_integ(n);
    chk(n, 200);
    cal <= 1'b0;
    $display("integration test done");
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    do_reset();
    t_reset();
    t_config();
    t_force();
    t_faults();
    t_tick();
    t_integ();
    tally_and_finish();
  end
endmodule // analog_input_module_cfg_status_bench
`default_nettype wire

// ==== test/front_end_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module front_end_model (
  // Clock, reset and tick control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_en_i,
  // Tick pin and point stream
  output logic ref_tick_o,
  output logic pt_wr_o,
  output logic [3:0] pt_idx_o,
  output logic [15:0] pt_dat_o
);
  logic [6:0] div_q;
  // Tick toggles every 80 cycles; a point sample every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= 7'h00;
      ref_tick_o <= 1'b0;
      pt_idx_o <= 4'h0;
    end else begin
      div_q <= (div_q == 7'h4f) ? 7'h00 : div_q + 7'h01;
      if (div_q == 7'h4f) ref_tick_o <= tick_en_i & ~ref_tick_o;
      pt_idx_o <= (pt_idx_o == 4'hb) ? 4'h0 : pt_idx_o + 4'h1;
    end
  end
  // Sample value carries its own index
  assign pt_wr_o = ~rst_i;
  assign pt_dat_o = {12'ha50, pt_idx_o};
endmodule // front_end_model
`default_nettype wire
